// ---- ssr_map.svh ----
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SSR_ADR_BAUD_CTL 8'h00
`define SSR_ADR_INT_CTL 8'h04
`define SSR_ADR_PER_IE 8'h08
`define SSR_ADR_PER_IF 8'h0c
`define SSR_ADR_RX_DATA 8'h10
`define SSR_ADR_RX_STAT 8'h14
`define SSR_ADR_TX_STAT 8'h18
`define SSR_ADR_TX_DATA 8'h1c
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSR_B_PORT_EN 7
`define SSR_B_NINTH_RX_EN 6
`define SSR_B_SINGLE_RX_EN 5
`define SSR_B_CONT_RX_EN 4
`define SSR_B_OVERRUN 1
`define SSR_B_RX_NINTH 0
`define SSR_B_CLK_SRC 7
`define SSR_B_NINTH_TX_EN 6
`define SSR_B_TX_EN 5
`define SSR_B_SYNC_MODE 4
`define SSR_B_TX_EMPTY 1
`define SSR_B_TX_NINTH 0
`define SSR_B_GLOBAL_IE 7
`define SSR_B_PERIPH_IE 6
`define SSR_B_RX_IRQ 5
`define SSR_B_TX_IRQ 4
`define SSR_B_RX_IDLE 6
`define SSR_B_CLK_POL 4
// ----------------------------------------------------------------
// Reset values, writable masks and constants
// ----------------------------------------------------------------
`define SSR_RST_RX_CTL 8'h00
`define SSR_RST_TX_CTL 8'h00
`define SSR_RST_INT_CTL 8'h00
`define SSR_RST_PER_IE 8'h00
`define SSR_RST_BAUD_CTL 8'h00
`define SSR_MASK_RX_CTL 8'hf0
`define SSR_MASK_TX_CTL 8'hf1
`define SSR_MASK_INT_CTL 8'hc0
`define SSR_MASK_PER_IE 8'h30
`define SSR_MASK_BAUD_CTL 8'h10
`define SSR_RX_DEPTH 2'd2
`define SSR_LAST_BIT_8 4'd7
`define SSR_LAST_BIT_9 4'd8
`define SSR_VECTOR_ADDR 12'h004
`endif

// ---- ssr_pin_sync.sv ----
// Two-stage synchroniser for a pin from outside the clock domain
module ssr_pin_sync (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_level
);
  logic meta_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      meta_q <= i_pin;
      o_level <= meta_q;
    end
  end
endmodule // ssr_pin_sync

// ---- ssr_pkg.sv ----
package ssr_pkg;
  typedef enum logic {SSR_TX_IDLE, SSR_TX_SHIFT} ssr_tx_state_t;
  typedef logic [8:0] ssr_word_t;
endpackage

// ---- ssr_serial_port.sv ----
`include "ssr_map.svh"

// Functional notes
// RULE_01: Slave receiver keeps receiving word after word, never idling.
// RULE_02: Single-receive enable has no effect in slave mode.
// RULE_03: Word received while sleeping moves from shift register into FIFO.
// RULE_04: Completed reception with receive enable wakes; global enable vectors.
// RULE_05: Software sets sync and port enable, clears clock source select.
// RULE_06: Software clears analog select on clock and data pins.
// RULE_07: Software sets continuous receive enable last during set-up.
// RULE_08: Ninth-bit mode stores MSB in status, low byte in FIFO.
// RULE_09: Receive flag set on complete word; request only with its enable.
// RULE_10: Clearing continuous receive or port enable clears overrun.
// RULE_11: Only synchronous slave mode shifts; other modes stay frozen. Here a shifting transmitter drops to idle instead.
// RULE_12: Shift registers advance on the external serial clock edges.
// RULE_13: Software empties receive FIFO before sleeping for reception.
// RULE_14: Master clocks a word in; device flags it and wakes.
// RULE_15: After waking, continue or call fixed vector when global enable.
// RULE_16: Software loads transmit data register before sleeping.
// RULE_17: Software sets transmit and peripheral enables before sleeping.
// RULE_18: Emptied shift register reloads pending byte and sets transmit flag.
// RULE_19: After reload, a transmit data write is accepted, clearing flag.
// RULE_20: Word completing with full FIFO sets overrun and is discarded.
module ssr_serial_port (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_data_pin,
  output logic o_serial_data_pin,
  output logic o_serial_data_pin_oe,
  input wire logic i_sleep,
  output logic o_wake,
  output logic o_vector_req,
  output logic [11:0] o_vector_addr
);
  // --------------------------------------------------------------
  // Pin synchronisers and clock edges
  // --------------------------------------------------------------
  logic clk_s, data_s, clk_prev_q, clk_eff, clk_prev_eff;
  logic rx_edge, tx_edge;

  ssr_pin_sync u_clk_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_serial_clock_pin),
    .o_level(clk_s)
  );
  ssr_pin_sync u_data_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_serial_data_pin),
    .o_level(data_s)
  );

  logic [7:0] rx_ctl_q, tx_ctl_q, int_ctl_q, per_ie_q, baud_ctl_q;
  logic port_rst, slave_mode, cont_rx, ninth_rx;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= clk_s;
  end

  // Polarity bit inverts the sampled clock; data out changes on the
  // rising edge of that clock and the device samples on its falling edge.
  assign clk_eff = clk_s ^ baud_ctl_q[`SSR_B_CLK_POL];
  assign clk_prev_eff = clk_prev_q ^ baud_ctl_q[`SSR_B_CLK_POL];
  assign tx_edge = clk_eff & ~clk_prev_eff; // [RULE_12]
  assign rx_edge = ~clk_eff & clk_prev_eff; // [RULE_12]

  // Slave only: external clock, no clock source; other modes hold the receiver and drop the transmitter to idle
  assign slave_mode = rx_ctl_q[`SSR_B_PORT_EN] & tx_ctl_q[`SSR_B_SYNC_MODE]
    & ~tx_ctl_q[`SSR_B_CLK_SRC]; // [RULE_11]
  assign port_rst = i_sys_rst | ~rx_ctl_q[`SSR_B_PORT_EN]; // [RULE_10]
  assign cont_rx = rx_ctl_q[`SSR_B_CONT_RX_EN];
  assign ninth_rx = rx_ctl_q[`SSR_B_NINTH_RX_EN];

  // --------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------
  logic ack_q, bus_hit, bus_wr, bus_rd;
  logic [31:0] rd_dat_q;
  logic [7:0] rd_byte;

  assign bus_hit = i_wb_cyc & i_wb_stb & ~ack_q;
  assign bus_wr = bus_hit & i_wb_we & i_wb_sel[0];
  assign bus_rd = bus_hit & ~i_wb_we;
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rd_dat_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      ack_q <= 1'b0;
      rd_dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= bus_hit;
      if (bus_rd)
        rd_dat_q <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      rx_ctl_q <= `SSR_RST_RX_CTL;
      tx_ctl_q <= `SSR_RST_TX_CTL;
      int_ctl_q <= `SSR_RST_INT_CTL;
      per_ie_q <= `SSR_RST_PER_IE;
      baud_ctl_q <= `SSR_RST_BAUD_CTL;
    end
    else if (bus_wr)
    begin
      if (i_wb_adr == `SSR_ADR_RX_STAT)
        rx_ctl_q <= i_wb_dat[7:0] & `SSR_MASK_RX_CTL;
      else if (i_wb_adr == `SSR_ADR_TX_STAT)
        tx_ctl_q <= i_wb_dat[7:0] & `SSR_MASK_TX_CTL;
      else if (i_wb_adr == `SSR_ADR_INT_CTL)
        int_ctl_q <= i_wb_dat[7:0] & `SSR_MASK_INT_CTL;
      else if (i_wb_adr == `SSR_ADR_PER_IE)
        per_ie_q <= i_wb_dat[7:0] & `SSR_MASK_PER_IE;
      else if (i_wb_adr == `SSR_ADR_BAUD_CTL)
        baud_ctl_q <= i_wb_dat[7:0] & `SSR_MASK_BAUD_CTL;
    end
  end

  // --------------------------------------------------------------
  // Receive shifter
  // --------------------------------------------------------------
  ssr_pkg::ssr_word_t rx_shift_q, rx_next, rx_word;
  logic [3:0] rx_cnt_q;
  logic overrun_q, rx_done, rx_push;
  logic [1:0] fifo_cnt_q;

  assign rx_next = {data_s, rx_shift_q[8:1]};
  assign rx_word = ninth_rx ? rx_next : {1'b0, rx_next[8:1]}; // [RULE_08]
  // Single-receive enable is never consulted here [RULE_02]
  assign rx_done = slave_mode & cont_rx & ~overrun_q & rx_edge
    & (rx_cnt_q == (ninth_rx ? `SSR_LAST_BIT_9 : `SSR_LAST_BIT_8));
  assign rx_push = rx_done & (fifo_cnt_q != `SSR_RX_DEPTH); // [RULE_03]

  always_ff @(posedge i_mclk)
  begin
    if (port_rst | ~cont_rx)
    begin
      rx_cnt_q <= 4'd0;
      rx_shift_q <= 9'h000;
    end
    else if (slave_mode & ~overrun_q & rx_edge)
    begin
      rx_shift_q <= rx_next;
      // Wraps straight into the next word: no idle state [RULE_01]
      rx_cnt_q <= rx_done ? 4'd0 : rx_cnt_q + 4'd1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (port_rst | ~cont_rx)
      overrun_q <= 1'b0; // [RULE_10]
    else if (rx_done & ~rx_push)
      overrun_q <= 1'b1; // [RULE_20]
  end

  // --------------------------------------------------------------
  // Receive FIFO
  // --------------------------------------------------------------
  ssr_pkg::ssr_word_t fifo_mem_q [2];
  logic fifo_wp_q, fifo_rp_q, rx_pop, rx_flag;

  assign rx_pop = bus_rd & (i_wb_adr == `SSR_ADR_RX_DATA)
    & (fifo_cnt_q != 2'd0);
  assign rx_flag = fifo_cnt_q != 2'd0; // [RULE_09]

  always_ff @(posedge i_mclk)
  begin
    if (port_rst)
    begin
      fifo_wp_q <= 1'b0;
      fifo_rp_q <= 1'b0;
      fifo_cnt_q <= 2'd0;
      fifo_mem_q[0] <= 9'h000;
      fifo_mem_q[1] <= 9'h000;
    end
    else
    begin
      if (rx_push)
      begin
        fifo_mem_q[fifo_wp_q] <= rx_word; // [RULE_08]
        fifo_wp_q <= ~fifo_wp_q;
      end
      if (rx_pop)
        fifo_rp_q <= ~fifo_rp_q;
      fifo_cnt_q <= fifo_cnt_q + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // --------------------------------------------------------------
  // Transmit buffer and shifter
  // --------------------------------------------------------------
  ssr_pkg::ssr_tx_state_t tx_state_q;
  ssr_pkg::ssr_word_t tx_buf_q, tx_shift_q;
  logic tx_buf_full_q, tx_load, tx_last, tx_write;
  logic [3:0] tx_cnt_q;

  assign tx_write = bus_wr & (i_wb_adr == `SSR_ADR_TX_DATA);
  assign tx_last = tx_cnt_q == (tx_ctl_q[`SSR_B_NINTH_TX_EN]
    ? `SSR_LAST_BIT_9 : `SSR_LAST_BIT_8);
  assign tx_load = slave_mode & tx_ctl_q[`SSR_B_TX_EN] & tx_buf_full_q
    & ((tx_state_q == ssr_pkg::SSR_TX_IDLE) | (tx_edge & tx_last));

  always_ff @(posedge i_mclk)
  begin
    if (port_rst)
    begin
      tx_buf_full_q <= 1'b0;
      tx_buf_q <= 9'h000;
    end
    else if (tx_write)
    begin
      // Write wins over a same-cycle reload so no byte is lost [RULE_19]
      tx_buf_full_q <= 1'b1;
      tx_buf_q <= {tx_ctl_q[`SSR_B_TX_NINTH], i_wb_dat[7:0]};
    end
    else if (tx_load)
      tx_buf_full_q <= 1'b0; // [RULE_18]
  end

  always_ff @(posedge i_mclk)
  begin
    if (port_rst)
    begin
      tx_state_q <= ssr_pkg::SSR_TX_IDLE;
      tx_shift_q <= 9'h000;
      tx_cnt_q <= 4'd0;
    end
    else if (tx_load)
    begin
      tx_state_q <= ssr_pkg::SSR_TX_SHIFT; // [RULE_18]
      tx_shift_q <= tx_buf_q;
      tx_cnt_q <= 4'd0;
    end
    else
    begin
      case (tx_state_q)
        ssr_pkg::SSR_TX_IDLE:
          tx_cnt_q <= 4'd0;
        ssr_pkg::SSR_TX_SHIFT:
          if (~slave_mode | ~tx_ctl_q[`SSR_B_TX_EN])
            tx_state_q <= ssr_pkg::SSR_TX_IDLE;
          else if (tx_edge)
          begin
            if (tx_last)
              tx_state_q <= ssr_pkg::SSR_TX_IDLE;
            tx_shift_q <= {1'b0, tx_shift_q[8:1]}; // [RULE_12]
            tx_cnt_q <= tx_cnt_q + 4'd1;
          end
        default:
          tx_state_q <= ssr_pkg::SSR_TX_IDLE;
      endcase
    end
  end

  assign o_serial_data_pin = tx_shift_q[0];
  assign o_serial_data_pin_oe = tx_state_q == ssr_pkg::SSR_TX_SHIFT;

  // --------------------------------------------------------------
  // Flags, wake and vector request
  // --------------------------------------------------------------
  logic tx_flag, pending;

  assign tx_flag = ~tx_buf_full_q; // [RULE_18]
  assign pending = int_ctl_q[`SSR_B_PERIPH_IE]
    & ((rx_flag & per_ie_q[`SSR_B_RX_IRQ])
    | (tx_flag & per_ie_q[`SSR_B_TX_IRQ])); // [RULE_09]
  assign o_wake = i_sleep & pending; // [RULE_04] [RULE_14]
  assign o_vector_req = pending & int_ctl_q[`SSR_B_GLOBAL_IE]; // [RULE_15]
  assign o_vector_addr = `SSR_VECTOR_ADDR;

  always_comb
  begin
    rd_byte = 8'h00;
    if (i_wb_adr == `SSR_ADR_RX_STAT)
      rd_byte = rx_ctl_q | {6'h00, overrun_q,
        fifo_mem_q[fifo_rp_q][8]}; // [RULE_08]
    else if (i_wb_adr == `SSR_ADR_TX_STAT)
      rd_byte = tx_ctl_q | {6'h00, o_serial_data_pin_oe == 1'b0, 1'b0};
    else if (i_wb_adr == `SSR_ADR_RX_DATA)
      rd_byte = fifo_mem_q[fifo_rp_q][7:0];
    else if (i_wb_adr == `SSR_ADR_PER_IF)
      rd_byte = {2'b00, rx_flag, tx_flag, 4'h0};
    else if (i_wb_adr == `SSR_ADR_PER_IE)
      rd_byte = per_ie_q;
    else if (i_wb_adr == `SSR_ADR_INT_CTL)
      rd_byte = int_ctl_q;
    else if (i_wb_adr == `SSR_ADR_BAUD_CTL)
      rd_byte = baud_ctl_q | {1'b0, rx_cnt_q == 4'd0, 6'h00};
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  logic rd_byte_rx9;
  assign rd_byte_rx9 = fifo_mem_q[fifo_rp_q][8];

  // A pop in the same cycle keeps the count level, so leave it out
  property p_rx_store;
    @(posedge i_mclk) disable iff (i_sys_rst)
    rx_push && !rx_pop |=> rx_flag
      && fifo_cnt_q == $past(fifo_cnt_q) + 2'd1;
  endproperty
  a_rx_store: assert property (p_rx_store) // [RULE_03]
    else $error("completed word not stored");

  property p_overrun;
    @(posedge i_mclk) disable iff (i_sys_rst)
    rx_done && fifo_cnt_q == 2'd2 && !rx_pop |=> overrun_q
      && fifo_cnt_q == 2'd2;
  endproperty
  a_overrun: assert property (p_overrun) // [RULE_20]
    else $error("overrun not flagged or word stored");

  property p_overrun_clear;
    @(posedge i_mclk) disable iff (i_sys_rst)
    !cont_rx || !rx_ctl_q[`SSR_B_PORT_EN] |=> !overrun_q;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) // [RULE_10]
    else $error("overrun not cleared");

  property p_port_reset;
    @(posedge i_mclk) disable iff (i_sys_rst)
    !rx_ctl_q[`SSR_B_PORT_EN] |=> fifo_cnt_q == 2'd0 && !o_serial_data_pin_oe;
  endproperty
  a_port_reset: assert property (p_port_reset) // [RULE_10]
    else $error("port not reset by disable");

  property p_ninth;
    @(posedge i_mclk) disable iff (i_sys_rst)
    rx_push && fifo_cnt_q == 2'd0 && !rx_pop
      |=> rd_byte_rx9 == $past(rx_word[8]);
  endproperty
  a_ninth: assert property (p_ninth) // [RULE_08]
    else $error("ninth bit not captured");

  property p_frozen;
    @(posedge i_mclk) disable iff (i_sys_rst)
    !$past(slave_mode) && $past(rx_ctl_q[`SSR_B_PORT_EN]) && cont_rx
      && $past(cont_rx) |-> $stable(rx_cnt_q);
  endproperty
  a_frozen: assert property (p_frozen) // [RULE_11]
    else $error("receiver shifted outside slave mode");

  property p_reload;
    @(posedge i_mclk) disable iff (i_sys_rst)
    tx_state_q == ssr_pkg::SSR_TX_SHIFT && tx_edge && tx_last
      && tx_buf_full_q && slave_mode && tx_ctl_q[`SSR_B_TX_EN] && !tx_write
      |=> tx_flag && o_serial_data_pin_oe && tx_cnt_q == 4'd0;
  endproperty
  a_reload: assert property (p_reload) // [RULE_18]
    else $error("pending byte not reloaded");

  property p_tx_write;
    @(posedge i_mclk) disable iff (i_sys_rst)
    tx_write && rx_ctl_q[`SSR_B_PORT_EN] |=> !tx_flag;
  endproperty
  a_tx_write: assert property (p_tx_write) // [RULE_19]
    else $error("write did not clear transmit flag");

  property p_wake;
    @(posedge i_mclk) disable iff (i_sys_rst)
    rx_push && i_sleep && per_ie_q[`SSR_B_RX_IRQ]
      && int_ctl_q[`SSR_B_PERIPH_IE] ##1 i_sleep |-> o_wake
      && (o_vector_req == int_ctl_q[`SSR_B_GLOBAL_IE])
      && o_vector_addr == `SSR_VECTOR_ADDR;
  endproperty
  a_wake: assert property (p_wake) // [RULE_04] [RULE_15]
    else $error("no wake after reception");

  property p_ack;
    @(posedge i_mclk) disable iff (i_sys_rst)
    bus_hit |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not one cycle");
endmodule // ssr_serial_port

// ---- ssr_serial_port_tb.sv ----
`include "ssr_map.svh"

module ssr_serial_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] A_RXS = `SSR_ADR_RX_STAT;
  localparam logic [7:0] A_TXS = `SSR_ADR_TX_STAT;
  localparam logic [7:0] A_PIF = `SSR_ADR_PER_IF;
  localparam logic [7:0] A_PIE = `SSR_ADR_PER_IE;
  localparam logic [7:0] A_INT = `SSR_ADR_INT_CTL;
  localparam logic [7:0] A_RXD = `SSR_ADR_RX_DATA;
  localparam logic [7:0] A_TXD = `SSR_ADR_TX_DATA;
  localparam logic [7:0] A_BAUD = `SSR_ADR_BAUD_CTL;
  logic i_mclk, i_sys_rst, cyc, stb, we, ack, sck, m_dat;
  logic dut_dat, dut_oe, dat_wire, sleep, wake, vreq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [11:0] vaddr;
  logic [8:0] q;
  int errors, total_checks;

  // Data wire: the device wins while it drives, else the master
  assign dat_wire = dut_oe ? dut_dat : m_dat;

  ssr_serial_port dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_serial_clock_pin(sck), .i_serial_data_pin(dat_wire),
    .o_serial_data_pin(dut_dat), .o_serial_data_pin_oe(dut_oe),
    .i_sleep(sleep), .o_wake(wake), .o_vector_req(vreq),
    .o_vector_addr(vaddr));

  ssr_sync_master mst (.o_clk(sck), .o_dat(m_dat), .i_dat(dat_wire));

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat[7:0];
    chk("wb_ack", 12'h001, {11'h000, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(nm, {4'h0, e}, {4'h0, r});
  endtask

  task automatic send(input logic [8:0] d, input int n);
    mst.frame(d, n, q);
    @(posedge i_mclk);
  endtask

  task automatic wait_wake();
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 50)
    begin
      @(posedge i_mclk);
      n++;
    end
    chk("wake", 12'h001, {11'h000, wake});
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200us;
    errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {cyc, stb, we, sleep, adr, wdat} = '0;
    sel = 4'h1;
    i_sys_rst = 1'b1;
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd("per_if", A_PIF, 8'h10);
    rd("baud_ctl", A_BAUD, 8'h40);
    rd("rx_stat", A_RXS, 8'h00);
    rd("tx_stat", A_TXS, 8'h02);
    wr(8'h20, 8'hff);
    rd("unmapped", 8'h20, 8'h00);
    // Pins have no analog select here, so they are digital already
    wr(A_TXS, 8'h10);
    wr(A_RXS, 8'h80);
    wr(A_PIE, 8'h20);
    wr(A_INT, 8'h40);
    wr(A_RXS, 8'hb0);
    sleep <= 1'b1;
    send(9'h0a5, 8);
    chk("wake", 12'h001, {11'h000, wake});
    chk("vector_req", 12'h000, {11'h000, vreq});
    rd("per_if", A_PIF, 8'h30);
    sleep <= 1'b0;
    rd("rx_data", A_RXD, 8'ha5);
    rd("per_if", A_PIF, 8'h10);
    wr(A_PIE, 8'h00);
    sleep <= 1'b1;
    send(9'h03c, 8);
    chk("wake", 12'h000, {11'h000, wake});
    sleep <= 1'b0;
    rd("rx_data", A_RXD, 8'h3c);
    wr(A_PIE, 8'h20);
    send(9'h011, 8);
    send(9'h022, 8);
    send(9'h033, 8);
    rd("rx_stat", A_RXS, 8'hb2);
    rd("rx_data", A_RXD, 8'h11);
    rd("rx_data", A_RXD, 8'h22);
    rd("per_if", A_PIF, 8'h10);
    wr(A_RXS, 8'h80);
    rd("rx_stat", A_RXS, 8'h80);
    wr(A_RXS, 8'h90);
    send(9'h044, 8);
    send(9'h055, 8);
    send(9'h066, 8);
    wr(A_RXS, 8'h00);
    rd("rx_stat", A_RXS, 8'h00);
    rd("per_if", A_PIF, 8'h10);
    wr(A_RXS, 8'h80);
    wr(A_RXS, 8'hd0);
    send(9'h15a, 9);
    rd("rx_stat", A_RXS, 8'hd1);
    rd("rx_data", A_RXD, 8'h5a);
    send(9'h0a5, 9);
    rd("rx_stat", A_RXS, 8'hd0);
    rd("rx_data", A_RXD, 8'ha5);
    wr(A_RXS, 8'h90);
    wr(A_INT, 8'hc0);
    send(9'h081, 8);
    chk("vector_req", 12'h001, {11'h000, vreq});
    chk("vector_addr", 12'h004, vaddr);
    chk("wake", 12'h000, {11'h000, wake});
    rd("rx_data", A_RXD, 8'h81);
    chk("vector_req", 12'h000, {11'h000, vreq});
    wr(A_INT, 8'h40);
    wr(A_TXS, 8'h90);
    send(9'h099, 8);
    rd("per_if", A_PIF, 8'h10);
    wr(A_RXS, 8'h80);
    wr(A_TXS, 8'h30);
    wr(A_PIE, 8'h10);
    wr(A_TXD, 8'h3c);
    wr(A_TXD, 8'hc3);
    rd("per_if", A_PIF, 8'h00);
    sleep <= 1'b1;
    send(9'h000, 8);
    chk("tx_word", 12'h03c, {3'h0, q});
    wait_wake();
    rd("per_if", A_PIF, 8'h10);
    sleep <= 1'b0;
    wr(A_TXD, 8'h77);
    rd("per_if", A_PIF, 8'h00);
    send(9'h000, 8);
    chk("tx_word", 12'h0c3, {3'h0, q});
    send(9'h000, 8);
    chk("tx_word", 12'h077, {3'h0, q});
    rd("tx_stat", A_TXS, 8'h32);
    chk("data_oe", 12'h000, {11'h000, dut_oe});
    finish_test();
  end
endmodule // ssr_serial_port_tb

// ---- ssr_sync_master.sv ----
// ----------------------------------------------------------------
// External synchronous master on the serial clock and data pins
// ----------------------------------------------------------------
module ssr_sync_master (
  output logic o_clk,
  output logic o_dat,
  input wire logic i_dat
);
  timeunit 1ns;
  timeprecision 100ps;
  parameter real HALF_NS = 62.5;

  // Clock idles high and stands still between frames
  initial
  begin
    o_clk = 1'b1;
    o_dat = 1'b0;
  end

  // LSB first: data set while high, taken on the fall
  // Device bit read at the end of the low phase
  task automatic frame(input logic [8:0] d, input int n,
                       output logic [8:0] q);
    q = 9'h000;
    for (int i = 0; i < n; i++)
    begin
      o_dat = d[i];
      #(HALF_NS);
      o_clk = 1'b0;
      #(HALF_NS);
      q[i] = i_dat;
      o_clk = 1'b1;
    end
    #(HALF_NS);
    // Released: show the inverse so a stale level is never trusted
    o_dat = ~o_dat;
  endtask
endmodule // ssr_sync_master
